// ==== rtl/timer_a_pkg.sv ====
// Constants, register map and field layout of the five-channel timer group
package timer_a_pkg;
   localparam int NCH = 5;
   localparam int AW = 4;
   localparam int DW = 16;
   // -------------------------------------------------
   // Register offsets (word index on the register port)
   // -------------------------------------------------
   localparam logic [3:0] ADDR_COUNT0 = 4'h0;
   localparam logic [3:0] ADDR_MODE0 = 4'h5;
   localparam logic [3:0] ADDR_START = 4'ha;
   localparam logic [3:0] ADDR_UDF = 4'hb;
   localparam logic [3:0] ADDR_TRIG = 4'hc;
   localparam logic [3:0] ADDR_ONESHOT = 4'hd;
   localparam logic [3:0] ADDR_IRQ2CTL = 4'he;
   // -------------------------------------------------
   // Field positions
   // -------------------------------------------------
   localparam int MR_PULSE = 2;
   localparam int MR_GATE_EN = 3;
   localparam int MR_EDGE = 3;
   localparam int MR_GATE_LVL = 4;
   localparam int MR_DIR_SRC = 4;
   localparam int MR_FREE = 5;
   localparam int MR_QSTYLE = 6;
   localparam int MR_CKS = 6;
   localparam int UDF_QEN = 5;
   localparam int OS_IDX_EN = 5;
   localparam int IC_POL = 4;
   // -------------------------------------------------
   // Encodings
   // -------------------------------------------------
   localparam logic [1:0] MODE_TIMER = 2'h0;
   localparam logic [1:0] MODE_EVENT = 2'h1;
   localparam logic [1:0] MODE_ONESHOT = 2'h2;
   localparam logic [1:0] MODE_PWM = 2'h3;
   localparam logic [1:0] TRG_PIN = 2'h0;
   localparam logic [1:0] TRG_B2 = 2'h1;
   localparam logic [1:0] TRG_PREV = 2'h2;
   localparam logic [1:0] TRG_NEXT = 2'h3;
   // -------------------------------------------------
   // Reset value, count limit and prescaler counts
   // -------------------------------------------------
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [4:0] DIV_F8 = 5'h07;
   localparam logic [4:0] DIV_FC32 = 5'h1f;
   localparam logic [4:0] DIV_F2N = 5'h0f;
endpackage

// ==== rtl/pin_sync.sv ====
// Two-stage synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
module pin_sync #(parameter int W = 11) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] lvl,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] last_reg;

   // Sync chain, then one stage for edge history
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
         last_reg <= '0;
      end
      else
      begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // Levels and one-cycle edges
   assign lvl = sync_reg;
   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;
endmodule

// ==== rtl/count_source_div.sv ====
// Prescaler producing the four internal count-source enables
`timescale 1ns/1ps
module count_source_div import timer_a_pkg::*; (
   input wire logic core_clk,
   input wire logic reset,
   output logic [3:0] src_en
);
   logic [4:0] div_reg;
   logic [4:0] f2n_reg;

   // Free-running dividers
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         div_reg <= 5'h00;
         f2n_reg <= 5'h00;
      end
      else
      begin
         div_reg <= div_reg + 5'h01;
         f2n_reg <= (f2n_reg == DIV_F2N) ? 5'h00 : f2n_reg + 5'h01;
      end
   end

   // Index 0: every cycle, 1: /8, 2: /2n, 3: /32
   assign src_en[0] = 1'b1;
   assign src_en[1] = (div_reg[2:0] == DIV_F8[2:0]);
   assign src_en[2] = (f2n_reg == DIV_F2N);
   assign src_en[3] = (div_reg == DIV_FC32);
endmodule

// ==== rtl/timer_a_counter_quadrature.sv ====
// Five-channel 16-bit timer group with event counting and quadrature decode
// Functional notes
// - Five independent 16-bit counters with reload
// - Two-bit field selects channel mode
// - Timer mode decrements, reloads on underflow
// - Channel counts only while run bit set
// - Interrupt on underflow, or overflow/underflow
// - Count register read returns counter value
// - Write loads counter only before first count
// - Gate pin level enables timer counting
// - Timer pulse output toggles, low when stopped
// - Event source: pin edge, neighbour wrap or timer B2 wrap
// - Event direction from flag or pin
// - Event reload on wrap unless free-running
// - Event pulse output toggles, low when stopped
// - Zero count value: no start, no interrupt, except in quadrature decode
// - Modulator mode zero value: idle, low output
// - Normal decode: input edges while phase high
// - Quadrupled decode counts all edges, latched direction
// - Ch2 normal, ch4 quadrupled, ch3 selectable
// - Ch3 index edge with polarity, gated reset
// - Index clears at next tick, double interrupt if that tick also wraps
`timescale 1ns/1ps
module timer_a_counter_quadrature import timer_a_pkg::*; (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [4:0] channel_input_pin,
   input wire logic [4:0] channel_output_pin_in,
   output logic [4:0] channel_output_pin_out,
   output logic [4:0] channel_output_pin_oe_n,
   input wire logic ext_irq2_pin,
   input wire logic tb2_wrap,
   output logic [4:0] channel_irq
);
   // -------------------------------------------------
   // Storage
   // -------------------------------------------------
   logic [15:0] cnt_reg [NCH];
   logic [15:0] reload_reg [NCH];
   logic [7:0] channel_mode_reg [NCH];
   logic [4:0] count_start_reg;
   logic [7:0] up_down_flag_reg;
   logic [9:0] trigger_select_reg;
   logic index_reset_enable_bit;
   logic edge_polarity_bit;
   logic idx_pend_reg;
   logic idx_extra_reg;
   logic [4:0] started_reg;
   logic [4:0] out_reg;
   logic [4:0] wrap_q_reg;
   logic [4:0] irq_reg;
   logic [4:0] tick;
   logic [4:0] wrap;
   logic [4:0] idx_hit;
   logic [10:0] pin_lvl;
   logic [10:0] pin_rise;
   logic [10:0] pin_fall;
   logic [3:0] src_en;
   logic idx_edge;
   logic idx_ok;

   // Counter next value: {wrap, value}
   function automatic logic [16:0] step(input logic [15:0] c, input logic up,
                                        input logic [15:0] rl, input logic fr);
      logic w;
      logic [15:0] n;
      w = up ? (c == CNT_MAX) : (c == RST_WORD);
      n = up ? c + 16'h0001 : c - 16'h0001;
      if (w && !fr)
      begin
         n = rl;
      end
      return {w, n};
   endfunction

   // -------------------------------------------------
   // Pin synchronisers and prescaler
   // -------------------------------------------------
   pin_sync #(.W(11)) u_sync (
      .core_clk(core_clk),
      .reset(reset),
      .pin({ext_irq2_pin, channel_output_pin_in, channel_input_pin}),
      .lvl(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   count_source_div u_div (
      .core_clk(core_clk),
      .reset(reset),
      .src_en(src_en)
   );

   // -------------------------------------------------
   // Configuration registers
   // -------------------------------------------------
   // Software writes to mode, start, flag and select registers
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            channel_mode_reg[i] <= 8'h00;
         end
         count_start_reg <= 5'h00;
         up_down_flag_reg <= 8'h00;
         trigger_select_reg <= 10'h000;
         index_reset_enable_bit <= 1'b0;
         edge_polarity_bit <= 1'b0;
      end
      else if (reg_wr)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            if (reg_addr == ADDR_MODE0 + 4'(i))
            begin
               channel_mode_reg[i] <= reg_wdata[7:0];
            end
         end
         case (reg_addr)
            ADDR_START: count_start_reg <= reg_wdata[4:0];
            ADDR_UDF: up_down_flag_reg <= reg_wdata[7:0];
            ADDR_TRIG: trigger_select_reg <= reg_wdata[9:0];
            ADDR_ONESHOT: index_reset_enable_bit <= reg_wdata[OS_IDX_EN];
            ADDR_IRQ2CTL: edge_polarity_bit <= reg_wdata[IC_POL];
            default: ;
         endcase
      end
   end

   // Registered read port, unmapped reads return zero
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         reg_rdata <= RST_WORD;
      end
      else if (reg_rd)
      begin
         reg_rdata <= RST_WORD;
         if (reg_addr < ADDR_MODE0)
         begin
            reg_rdata <= cnt_reg[reg_addr[2:0]];
         end
         else if (reg_addr < ADDR_START)
         begin
            reg_rdata <= {8'h00, channel_mode_reg[3'(reg_addr - ADDR_MODE0)]};
         end
         else
         begin
            case (reg_addr)
               ADDR_START: reg_rdata <= {11'h000, count_start_reg};
               ADDR_UDF: reg_rdata <= {8'h00, up_down_flag_reg};
               ADDR_TRIG: reg_rdata <= {6'h00, trigger_select_reg};
               ADDR_ONESHOT: reg_rdata <= {10'h000, index_reset_enable_bit, 5'h00};
               ADDR_IRQ2CTL: reg_rdata <= {11'h000, edge_polarity_bit, 4'h0};
               default: reg_rdata <= RST_WORD;
            endcase
         end
      end
   end

   // -------------------------------------------------
   // Index (Z-phase) reset on channel 3
   // -------------------------------------------------
   assign idx_edge = edge_polarity_bit ? pin_rise[10] : pin_fall[10];
   assign idx_ok = index_reset_enable_bit && channel_mode_reg[3][1:0] == MODE_EVENT
                   && up_down_flag_reg[UDF_QEN + 1] && channel_mode_reg[3][MR_FREE]
                   && channel_mode_reg[3][MR_QSTYLE];
   assign idx_hit = {1'b0, tick[3] && idx_pend_reg, 3'b000};

   // Pending index waits for the next count tick; a new edge wins
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         idx_pend_reg <= 1'b0;
         idx_extra_reg <= 1'b0;
      end
      else
      begin
         if (idx_edge && idx_ok)
         begin
            idx_pend_reg <= 1'b1;
         end
         else if (tick[3] || !idx_ok)
         begin
            idx_pend_reg <= 1'b0;
         end
         idx_extra_reg <= idx_hit[3] && wrap[3];
      end
   end

   // -------------------------------------------------
   // Channels
   // -------------------------------------------------
   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      localparam int PV = (i + NCH - 1) % NCH;
      localparam int NX = (i + 1) % NCH;
      localparam int QB = (i >= 2) ? UDF_QEN + i - 2 : 0;
      logic [7:0] mr;
      logic [1:0] md;
      logic [1:0] trg;
      logic quad;
      logic quad4;
      logic ph;
      logic ev;
      logic ev_q;
      logic up_q;
      logic up;
      logic gate_ok;
      logic nz;
      logic qdir_reg;
      logic cnt_wr;
      logic load_now;
      logic [16:0] nxt;

      assign mr = channel_mode_reg[i];
      assign md = mr[1:0];
      assign trg = trigger_select_reg[2 * i +: 2];
      assign quad = (i >= 2) && md == MODE_EVENT && up_down_flag_reg[QB];
      assign quad4 = (i == 4) || (i == 3 && mr[MR_QSTYLE]);
      assign ph = pin_lvl[5 + i];
      assign nz = (reload_reg[i] != RST_WORD) || quad;
      assign gate_ok = !mr[MR_GATE_EN] || (pin_lvl[i] == mr[MR_GATE_LVL]);
      // Event source selection
      always_comb
      begin
         case (trg)
            TRG_PIN: ev = mr[MR_EDGE] ? pin_rise[i] : pin_fall[i];
            TRG_B2: ev = tb2_wrap;
            TRG_PREV: ev = wrap_q_reg[PV];
            TRG_NEXT: ev = wrap_q_reg[NX];
            default: ev = 1'b0;
         endcase
      end
      // Two-phase decode
      assign ev_q = quad4 ? (pin_rise[i] | pin_fall[i] | pin_rise[5 + i] | pin_fall[5 + i])
                          : (ph && (pin_rise[i] | pin_fall[i]));
      assign up_q = quad4 ? ((ph && pin_rise[i]) ? 1'b1 : (ph && pin_fall[i]) ? 1'b0
                          : qdir_reg) : pin_rise[i];
      // Count tick and direction
      assign tick[i] = count_start_reg[i] && nz && ((md == MODE_TIMER
                       && src_en[mr[MR_CKS +: 2]] && gate_ok)
                       || (md == MODE_EVENT && (quad ? ev_q : ev)));
      assign up = (md == MODE_TIMER) ? 1'b0 : quad ? up_q
                  : (mr[MR_DIR_SRC] ? ph : up_down_flag_reg[i]);
      assign nxt = step(cnt_reg[i], up, reload_reg[i],
                        md == MODE_EVENT && mr[MR_FREE]);
      assign wrap[i] = tick[i] && nxt[16];
      assign cnt_wr = reg_wr && reg_addr == ADDR_COUNT0 + 4'(i);
      assign load_now = cnt_wr && (!count_start_reg[i] || !started_reg[i]);

      // Latched quadrupled direction
      always_ff @(posedge core_clk)
      begin
         if (reset)
         begin
            qdir_reg <= 1'b0;
         end
         else if (ph && (pin_rise[i] || pin_fall[i]))
         begin
            qdir_reg <= pin_rise[i];
         end
      end

      // Counter, reload value and first-tick tracking
      always_ff @(posedge core_clk)
      begin
         if (reset)
         begin
            cnt_reg[i] <= RST_WORD;
            reload_reg[i] <= RST_WORD;
            started_reg[i] <= 1'b0;
         end
         else
         begin
            if (cnt_wr)
            begin
               reload_reg[i] <= reg_wdata;
            end
            if (!count_start_reg[i])
            begin
               started_reg[i] <= 1'b0;
            end
            else if (tick[i])
            begin
               started_reg[i] <= 1'b1;
            end
            if (load_now)
            begin
               cnt_reg[i] <= reg_wdata;
            end
            else if (idx_hit[i])
            begin
               cnt_reg[i] <= RST_WORD;
            end
            else if (tick[i])
            begin
               cnt_reg[i] <= nxt[15:0];
            end
         end
      end

      // Pulse output, interrupt and wrap for neighbours
      always_ff @(posedge core_clk)
      begin
         if (reset)
         begin
            out_reg[i] <= 1'b0;
            irq_reg[i] <= 1'b0;
            wrap_q_reg[i] <= 1'b0;
         end
         else
         begin
            if (!count_start_reg[i])
            begin
               out_reg[i] <= 1'b0;
            end
            else if (wrap[i] && mr[MR_PULSE])
            begin
               out_reg[i] <= ~out_reg[i];
            end
            irq_reg[i] <= wrap[i] || (i == 3 && idx_extra_reg);
            wrap_q_reg[i] <= wrap[i];
         end
      end

      // Pin drives only as pulse output, otherwise it is an input
      assign channel_output_pin_oe_n[i] = !(mr[MR_PULSE] && !(md == MODE_EVENT
                                          && (quad || mr[MR_DIR_SRC])));
   end

   assign channel_output_pin_out = out_reg;
   assign channel_irq = irq_reg;

   // -------------------------------------------------
   // Assertions
   // -------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   property p_stop_hold;
      !count_start_reg[0] && !(reg_wr && reg_addr == ADDR_COUNT0) |=> $stable(cnt_reg[0]);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");

   property p_timer_reload;
      tick[0] && channel_mode_reg[0][1:0] == MODE_TIMER && cnt_reg[0] == 16'h0000
      && !(reg_wr && reg_addr == ADDR_COUNT0) |=> cnt_reg[0] == $past(reload_reg[0]);
   endproperty
   a_timer_reload: assert property (p_timer_reload) else $error("no reload");

   property p_timer_dec;
      tick[0] && channel_mode_reg[0][1:0] == MODE_TIMER && cnt_reg[0] != 16'h0000
      && !(reg_wr && reg_addr == ADDR_COUNT0) |=> cnt_reg[0] == $past(cnt_reg[0]) - 16'h0001;
   endproperty
   a_timer_dec: assert property (p_timer_dec) else $error("bad decrement");

   property p_irq_wrap;
      wrap[1] |=> channel_irq[1];
   endproperty
   a_irq_wrap: assert property (p_irq_wrap) else $error("missing interrupt");

   property p_zero_quiet;
      reload_reg[0] == 16'h0000 |=> !channel_irq[0] && $stable(cnt_reg[0])
         || $past(reg_wr);
   endproperty
   a_zero_quiet: assert property (p_zero_quiet) else $error("zero value ran");

   property p_read;
      reg_rd && reg_addr == ADDR_COUNT0 |=> reg_rdata == $past(cnt_reg[0]);
   endproperty
   a_read: assert property (p_read) else $error("bad count read");

   property p_wr_stopped;
      reg_wr && reg_addr == ADDR_COUNT0 && !count_start_reg[0]
      |=> cnt_reg[0] == $past(reg_wdata) && reload_reg[0] == $past(reg_wdata);
   endproperty
   a_wr_stopped: assert property (p_wr_stopped) else $error("write not loaded");

   property p_out_low;
      !count_start_reg[2] ##1 !count_start_reg[2] |-> !channel_output_pin_out[2];
   endproperty
   a_out_low: assert property (p_out_low) else $error("output high while stopped");

   property p_toggle;
      wrap[0] && channel_mode_reg[0][MR_PULSE] && count_start_reg[0]
      |=> channel_output_pin_out[0] != $past(channel_output_pin_out[0]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("no toggle");

   property p_index_clear;
      idx_hit[3] && !(reg_wr && reg_addr == ADDR_COUNT0 + 4'h3) |=> cnt_reg[3] == 16'h0000;
   endproperty
   a_index_clear: assert property (p_index_clear) else $error("index not cleared");

   property p_double_irq;
      idx_hit[3] && wrap[3] |=> channel_irq[3] ##1 channel_irq[3];
   endproperty
   a_double_irq: assert property (p_double_irq) else $error("single interrupt");

   c_timer_wrap: cover property (wrap[0] && channel_mode_reg[0][1:0] == MODE_TIMER);
   c_quad_up: cover property (tick[4] && g_ch[4].up);
   c_index: cover property (idx_hit[3]);
endmodule

// ==== dv/quad_enc_model.sv ====
// Two-phase encoder model driving phase A and phase B pin levels
`timescale 1ns/1ps
module quad_enc_model #(parameter int HOLD = 8) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic go,
   input wire logic fwd,
   input wire logic [7:0] quarters,
   output logic phase_a,
   output logic phase_b,
   output logic busy
);
   logic [1:0] pos_reg;
   logic [7:0] left_reg;
   logic [7:0] tmr_reg;
   logic dir_reg;
   // One quarter step per HOLD cycles, phase A leads when forward
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         pos_reg <= 2'h0;
         left_reg <= 8'h00;
         tmr_reg <= 8'h00;
         dir_reg <= 1'b0;
      end
      else if (go && left_reg == 8'h00)
      begin
         left_reg <= quarters;
         tmr_reg <= 8'h00;
         dir_reg <= fwd;
      end
      else if (left_reg != 8'h00)
      begin
         if (tmr_reg == 8'(HOLD - 1))
         begin
            tmr_reg <= 8'h00;
            left_reg <= left_reg - 8'h01;
            pos_reg <= dir_reg ? pos_reg + 2'h1 : pos_reg - 2'h1;
         end
         else
            tmr_reg <= tmr_reg + 8'h01;
      end
   end
   // Gray sequence: only one phase changes per step
   assign phase_a = pos_reg[0] ^ pos_reg[1];
   assign phase_b = pos_reg[1];
   assign busy = left_reg != 8'h00;
endmodule

// ==== dv/test_timer_a_counter_quadrature.sv ====
// Self-checking bench for the five-channel timer group
`timescale 1ns/1ps
module test_timer_a_counter_quadrature import timer_a_pkg::*;;
   logic core_clk, reset, reg_wr, reg_rd, ext_irq2_pin, tb2_wrap, go, fwd, busy, qa, qb;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, v, a;
   logic [4:0] pin_out, oe_n, irq, out_in;
   logic [1:0] pin, extb;
   logic [7:0] quarters;
   logic found, o1;
   int cyc = 0, t1, t2, t3, fail_count = 0, total_checks = 0;
   int divs[4];
   // Pin levels: driven output wins where the module enables it
   assign out_in = oe_n & {qb, qb, qb, extb} | ~oe_n & pin_out;
   timer_a_counter_quadrature timer_a_counter_quadrature_i (.core_clk(core_clk),
      .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_input_pin({qa, qa, qa, pin}),
      .channel_output_pin_in(out_in), .channel_output_pin_out(pin_out),
      .channel_output_pin_oe_n(oe_n), .ext_irq2_pin(ext_irq2_pin), .tb2_wrap(tb2_wrap),
      .channel_irq(irq));
   quad_enc_model quad_enc_model_i (.core_clk(core_clk), .reset(reset), .go(go), .fwd(fwd),
      .quarters(quarters), .phase_a(qa), .phase_b(qb), .busy(busy));
   // ----------------------------------------
   // Clock and timeout
   // ----------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] ad);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // Look for one irq pulse within lim cycles
   task automatic wait_irq(input int ch, input int lim, output int t);
      found = 1'b0;
      for (int k = 0; k < lim && !found; k++)
      begin
         @(posedge core_clk);
         #1;
         if (irq[ch] === 1'b1)
         begin
            found = 1'b1;
            t = cyc;
         end
      end
   endtask
   task automatic pinp();
      @(posedge core_clk) pin[1] <= 1'b1;
      repeat (6) @(posedge core_clk);
      pin[1] <= 1'b0;
      repeat (6) @(posedge core_clk);
   endtask
   task automatic quad(input logic f, input logic [7:0] n);
      @(posedge core_clk);
      go <= 1'b1;
      fwd <= f;
      quarters <= n;
      @(posedge core_clk) go <= 1'b0;
      // Look at busy only once the model has taken the request
      #1;
      for (int k = 0; k < 3000 && busy !== 1'b0; k++)
         @(posedge core_clk) #1;
      repeat (6) @(posedge core_clk);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {reset, reg_wr, reg_rd, ext_irq2_pin, tb2_wrap, go, fwd} = 7'h40;
      {reg_addr, reg_wdata, pin, extb, quarters} = 32'h0;
      divs = '{1, DIV_F8 + 1, DIV_F2N + 1, DIV_FC32 + 1};
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         rd(4'(i));
         chk("reset word", v, 16'h0000);
      end
      for (int s = 0; s < 4; s++)
      begin
         wr(ADDR_MODE0, 16'(s * 64 + 4));
         wr(ADDR_COUNT0, 16'h0001);
         wr(ADDR_START, 16'h0001);
         wait_irq(0, 200, t1);
         o1 = pin_out[0];
         wait_irq(0, 200, t2);
         chk("timer period", 16'(t2 - t1), 16'(2 * divs[s]));
         chk("pulse toggle", 16'(o1 ^ pin_out[0]), 16'h0001);
         chk("pin drive", 16'(oe_n[0]), 16'h0000);
         wr(ADDR_START, 16'h0000);
         // Output clears one edge after the run bit drops
         @(posedge core_clk);
         #1;
         chk("stopped out", 16'(pin_out[0]), 16'h0000);
      end
      wr(ADDR_MODE0, 16'h0044);
      wr(ADDR_COUNT0, 16'h0003);
      wr(ADDR_START, 16'h0001);
      wait_irq(0, 200, t1);
      wr(ADDR_COUNT0, 16'h0007);
      rd(ADDR_COUNT0);
      chk("running write", 16'(v < 16'h0004), 16'h0001);
      wait_irq(0, 200, t2);
      wait_irq(0, 200, t3);
      chk("new period", 16'(t3 - t2), 16'(8 * divs[1]));
      wr(ADDR_START, 16'h0000);
      wr(ADDR_MODE0, 16'h0018);
      wr(ADDR_COUNT0, 16'h0100);
      wr(ADDR_START, 16'h0001);
      rd(ADDR_COUNT0);
      a = v;
      rd(ADDR_COUNT0);
      chk("gate closed", v, a);
      @(posedge core_clk) pin[0] <= 1'b1;
      repeat (8) @(posedge core_clk);
      rd(ADDR_COUNT0);
      chk("gate open", 16'(v < a), 16'h0001);
      wr(ADDR_START, 16'h0000);
      for (int m = 0; m < 2; m++)
      begin
         wr(ADDR_MODE0 + 4'h1, m ? 16'h0007 : 16'h0004);
         wr(ADDR_START, 16'h0002);
         wait_irq(1, 60, t1);
         chk("zero irq", 16'(found), 16'h0000);
         chk("zero out", 16'(pin_out[1]), 16'h0000);
         wr(ADDR_START, 16'h0000);
      end
      for (int f = 0; f < 2; f++)
      begin
         wr(ADDR_MODE0 + 4'h1, 16'(25 + f * 32));
         wr(ADDR_COUNT0 + 4'h1, 16'hfffe);
         wr(ADDR_START, 16'h0002);
         extb[1] <= 1'b1;
         pinp();
         rd(ADDR_COUNT0 + 4'h1);
         chk("up edge", v, 16'hffff);
         pinp();
         rd(ADDR_COUNT0 + 4'h1);
         chk("overflow", v, f ? 16'h0000 : 16'hfffe);
         extb[1] <= 1'b0;
         repeat (6) @(posedge core_clk);
         pinp();
         rd(ADDR_COUNT0 + 4'h1);
         chk("down edge", v, f ? 16'hffff : 16'hfffd);
         wr(ADDR_START, 16'h0000);
      end
      wr(ADDR_MODE0 + 4'h1, 16'h0001);
      wr(ADDR_TRIG, 16'h0004);
      wr(ADDR_COUNT0 + 4'h1, 16'h0005);
      wr(ADDR_START, 16'h0002);
      repeat (2)
      begin
         @(posedge core_clk) tb2_wrap <= 1'b1;
         @(posedge core_clk) tb2_wrap <= 1'b0;
         repeat (3) @(posedge core_clk);
      end
      rd(ADDR_COUNT0 + 4'h1);
      chk("other group source", v, 16'h0003);
      wr(ADDR_TRIG, 16'h0000);
      wr(ADDR_UDF, 16'h00e0);
      wr(ADDR_MODE0 + 4'h2, 16'h0021);
      wr(ADDR_MODE0 + 4'h3, 16'h0061);
      wr(ADDR_MODE0 + 4'h4, 16'h0021);
      wr(ADDR_START, 16'h001c);
      quad(1'b0, 8'h04);
      rd(ADDR_COUNT0 + 4'h4);
      a = v;
      quad(1'b0, 8'h08);
      rd(ADDR_COUNT0 + 4'h2);
      chk("normal up", v, 16'h0003);
      chk("phase input", 16'(oe_n[4]), 16'h0001);
      rd(ADDR_COUNT0 + 4'h4);
      chk("quad up", v, a + 16'h0008);
      quad(1'b1, 8'h04);
      rd(ADDR_COUNT0 + 4'h4);
      a = v;
      quad(1'b1, 8'h08);
      rd(ADDR_COUNT0 + 4'h2);
      chk("normal down", v, 16'h0000);
      rd(ADDR_COUNT0 + 4'h4);
      chk("quad down", v, a - 16'h0008);
      rd(ADDR_COUNT0 + 4'h3);
      chk("ch3 quadrupled", v, a - 16'h0008);
      wr(ADDR_COUNT0 + 4'h3, 16'h0000);
      wr(ADDR_ONESHOT, 16'h0020);
      wr(ADDR_IRQ2CTL, 16'h0010);
      @(posedge core_clk) ext_irq2_pin <= 1'b1;
      quad(1'b0, 8'h01);
      ext_irq2_pin <= 1'b0;
      rd(ADDR_COUNT0 + 4'h3);
      chk("index clear", v, 16'h0000);
      end_of_test();
   end
endmodule
